//--- core/swc_spi_target.sv
// serial target logic controlling an eight-switch bank
// assumes mode 3 timing (sclk high while cs_n high), sdo pulled up outside
//
// Overview of operation
// RULE1: address-mode frame spans cs_n low, exactly sixteen sclk cycles.
// RULE2: first bit in chooses write when 0, read when 1.
// RULE3: then seven address bits msb first, then eight data bits ignored on reads.
// RULE4: reads shift register contents out on falling edges nine to sixteen.
// RULE5: without crc a write lands on the sixteenth rising edge.
// RULE6: every command first sends alignment byte 0x25 on falling edges one to eight.
// RULE7: sdi sampled on rising sclk, sdo changed on falling sclk.
// RULE8: sdo only pulls low, otherwise released for the external pull-up.
// RULE9: crc adds eight cycles, polynomial x8+x2+x+1, seed zero, over sixteen bits.
// RULE10: crc byte checked at the 24th rising edge; mismatch blocks write, sets flag.
// RULE11: reads with crc on append a crc byte on sdo.
// RULE12: three checks with enables and flags; crc off, clock and address on at reset.
// RULE13: wrong clock count sets flag; short frame writes nothing, long still writes.
// RULE14: bad address or read-only write found at ninth edge sets flag, blocks write.
// RULE15: frame 0x6CA9 with good crc clears all flags, raises no address error.
// RULE16: burst mode takes back-to-back commands in one frame, sdo stays aligned.
// RULE17: burst frame length must be a multiple of sixteen, or 24 with crc.
// RULE18: writing 0xA3 then 0x05 to software_reset_trigger resets all registers.
// RULE19: command 0x2500 enters daisy chain, echoed onward; only hardware reset leaves.
// RULE20: daisy sdo is sdi delayed eight cycles, starts at 0x00, survives cs_n.
// RULE21: daisy frames load last eight bits into switch state at cs_n rise.
// RULE22: host waits 120 us after any reset before the first command.
// RULE23: switch bit n closes switch n+1 when 1, applied at cs_n rise.
// RULE24: hardware reset opens all switches and restores register defaults.
// RULE25: error flags stay set until the clear frame or a reset.
module swc_spi_target #(
    parameter int INIT_CYCLES = swc_pkg::INIT_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    output logic [7:0] switch_closed,
    output logic init_done
);

    generate
        if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
            $error("INIT_CYCLES must lie in 1..65535");
        end
    endgenerate

    // crc over a 16-bit payload, msb first
    function automatic logic [7:0] swc_crc8(input logic [15:0] payload);
        logic [7:0] c;
        c = swc_pkg::CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ payload[i]) begin
                c = {c[6:0], 1'b0} ^ swc_pkg::CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    // link side state, all on sclk
    swc_pkg::swc_regs_t regs;
    swc_pkg::swc_regs_t next_regs;
    swc_pkg::swc_mode_t mode;
    logic [23:0] sh;
    logic [23:0] next_sh;
    logic [4:0] pos;
    logic [4:0] next_pos;
    logic fresh;
    logic seen;
    logic cnt_ok;
    logic addr_bad;
    logic arm;
    logic is_read;
    logic [7:0] rd_data;
    logic [7:0] rd_crc;
    logic srst_tgl;

    // per-edge decode
    logic crc_on;
    logic [4:0] cmd_len;
    logic cmd_end;
    logic [15:0] cmd;
    logic crc_ok;
    logic commit;
    logic soft_reset;
    logic daisy_entry;
    logic clk_err;
    logic addr_err;
    logic crc_err;
    logic [7:0] first_byte;
    logic [7:0] read_mux;

    always_comb begin
        crc_on = regs.cfg[swc_pkg::ERR_CRC];
        cmd_len = crc_on ? 5'(swc_pkg::CRC_FRAME_BITS) : 5'(swc_pkg::CMD_BITS);
        next_sh = {sh[22:0], sdi}; // RULE7
        if (fresh) begin
            next_pos = 5'd1;
        end else if (pos == 5'd31) begin
            next_pos = pos;
        end else begin
            next_pos = 5'(pos + 5'd1);
        end
        cmd_end = mode == swc_pkg::SWC_ADDR_MODE && next_pos == cmd_len; // RULE1
        cmd = crc_on ? next_sh[23:8] : next_sh[15:0]; // RULE3
        crc_ok = swc_crc8(next_sh[23:8]) == next_sh[7:0]; // RULE9
        commit = cmd_end && !cmd[15] && !addr_bad && (!crc_on || crc_ok); // RULE2 RULE5 RULE10
        crc_err = cmd_end && crc_on && !crc_ok && !cmd[15]; // RULE10
        soft_reset = commit && arm && cmd == swc_pkg::SRST_SECOND_CMD; // RULE18
        daisy_entry = commit && cmd == swc_pkg::DAISY_ENTRY_CMD; // RULE19
        first_byte = next_sh[8:1];
    end

    // register contents as seen by a read, reserved bits zero
    always_comb begin
        unique case (next_sh[6:0])
            swc_pkg::ADDR_SWITCH: read_mux = regs.sw;
            swc_pkg::ADDR_ERR_CFG: read_mux = {5'h0, regs.cfg};
            swc_pkg::ADDR_ERR_FLAGS: read_mux = {5'h0, regs.flags};
            swc_pkg::ADDR_BURST: read_mux = {7'h0, regs.burst};
            swc_pkg::ADDR_SRST: read_mux = regs.srst;
            default: read_mux = 8'h00;
        endcase
    end

    // address check on the ninth edge; the clear and daisy words are exempt
    always_comb begin
        addr_err = 1'b0;
        if (mode == swc_pkg::SWC_ADDR_MODE && !fresh && next_pos == 5'(swc_pkg::ADDR_DECIDE_BIT)) begin
            unique case (first_byte[6:0])
                swc_pkg::ADDR_SWITCH,
                swc_pkg::ADDR_ERR_CFG,
                swc_pkg::ADDR_BURST,
                swc_pkg::ADDR_SRST: addr_err = 1'b0;
                swc_pkg::ADDR_ERR_FLAGS: addr_err = !first_byte[7]; // RULE14
                default: addr_err = first_byte != swc_pkg::CLEAR_FLAGS_CMD[15:8]
                    && first_byte != swc_pkg::DAISY_ENTRY_CMD[15:8]; // RULE14 RULE15
            endcase
        end
    end

    // the count of the frame just ended is judged at the first edge of the next
    // frame; flags are only visible through later frames, so nothing is lost
    assign clk_err = fresh && seen && !cnt_ok && mode == swc_pkg::SWC_ADDR_MODE; // RULE13 RULE17

    always_comb begin
        next_regs = regs;
        if (fresh && mode == swc_pkg::SWC_DAISY_MODE) begin
            next_regs.sw = sh[7:0]; // RULE21
        end
        if (commit && cmd == swc_pkg::CLEAR_FLAGS_CMD) begin
            next_regs.flags = 3'h0; // RULE15
        end else if (commit) begin
            unique case (cmd[14:8])
                swc_pkg::ADDR_SWITCH: next_regs.sw = cmd[7:0]; // RULE23
                swc_pkg::ADDR_ERR_CFG: next_regs.cfg = cmd[2:0]; // RULE12
                swc_pkg::ADDR_BURST: next_regs.burst = cmd[0];
                swc_pkg::ADDR_SRST: next_regs.srst = cmd[7:0];
                default: next_regs.sw = next_regs.sw;
            endcase
        end
        // a set in the same edge as the clear survives
        if (crc_err) begin
            next_regs.flags[swc_pkg::ERR_CRC] = 1'b1; // RULE10 RULE25
        end
        if (clk_err && regs.cfg[swc_pkg::ERR_CLK]) begin
            next_regs.flags[swc_pkg::ERR_CLK] = 1'b1; // RULE13 RULE25
        end
        if (addr_err && regs.cfg[swc_pkg::ERR_ADDR]) begin
            next_regs.flags[swc_pkg::ERR_ADDR] = 1'b1; // RULE14 RULE25
        end
        if (soft_reset) begin
            next_regs = swc_pkg::REGS_RST; // RULE18
        end
    end

    // cs_n high marks the next edge as the start of a frame
    always_ff @(posedge sclk or posedge rst or posedge cs_n) begin
        if (rst) begin
            fresh <= 1'b1;
        end else if (cs_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            regs <= swc_pkg::REGS_RST; // RULE24
        end else if (!cs_n) begin
            regs <= next_regs;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            pos <= 5'd0;
            seen <= 1'b0;
            cnt_ok <= 1'b1;
        end else if (!cs_n) begin
            seen <= 1'b1;
            if (cmd_end && regs.burst) begin
                pos <= 5'd0; // RULE16
            end else begin
                pos <= next_pos;
            end
            cnt_ok <= cmd_end; // RULE13 RULE17
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            sh <= 24'h0000_0000;
        end else if (!cs_n) begin
            if (daisy_entry) begin
                sh <= 24'h0000_0000; // RULE20
            end else begin
                sh <= next_sh; // RULE20
            end
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            mode <= swc_pkg::SWC_ADDR_MODE; // RULE24
        end else if (!cs_n && daisy_entry) begin
            mode <= swc_pkg::SWC_DAISY_MODE; // RULE19
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            addr_bad <= 1'b0;
        end else if (!cs_n && !fresh && next_pos == 5'(swc_pkg::ADDR_DECIDE_BIT)) begin
            addr_bad <= addr_err; // RULE14
        end
    end

    // two writes to the reset register must be consecutive commands
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            arm <= 1'b0;
        end else if (!cs_n && cmd_end) begin
            arm <= commit && cmd == swc_pkg::SRST_FIRST_CMD && !soft_reset; // RULE18
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            srst_tgl <= 1'b0;
        end else if (!cs_n && soft_reset) begin
            srst_tgl <= !srst_tgl;
        end
    end

    // read data and its crc are latched once the address is known
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            is_read <= 1'b0;
            rd_data <= 8'h00;
            rd_crc <= 8'h00;
        end else if (!cs_n && next_pos == 5'(swc_pkg::READ_DECIDE_BIT)) begin
            is_read <= next_sh[7];
            if (next_sh[7]) begin
                rd_data <= read_mux; // RULE4
                rd_crc <= swc_crc8({next_sh[7:0], read_mux}); // RULE11
            end else begin
                // writes answer with zero data, which makes the daisy entry echo
                rd_data <= 8'h00; // RULE19
                rd_crc <= 8'h00;
            end
        end
    end

    // sdo, changed on falling edges and released as soon as cs_n rises
    logic [5:0] out_idx;
    logic [23:0] tx_word;
    logic out_bit;
    logic out_drive;

    always_comb begin
        // widen before adding so a saturated position cannot wrap back into the drive window
        out_idx = fresh ? 6'd1 : 6'(pos) + 6'd1;
        tx_word = {swc_pkg::ALIGN_PATTERN, rd_data, rd_crc};
        out_bit = 1'b1;
        out_drive = 1'b0;
        if (mode == swc_pkg::SWC_DAISY_MODE) begin
            out_bit = sh[7]; // RULE20
            out_drive = 1'b1;
        end else if (out_idx <= 6'(swc_pkg::CMD_BITS)) begin
            out_bit = tx_word[5'(6'd24 - out_idx)]; // RULE4 RULE6
            out_drive = 1'b1;
        end else if (out_idx <= 6'(swc_pkg::CRC_FRAME_BITS) && crc_on && is_read) begin
            out_bit = tx_word[5'(6'd24 - out_idx)]; // RULE11
            out_drive = 1'b1;
        end
    end

    always_ff @(negedge sclk or posedge rst or posedge cs_n) begin
        if (rst) begin
            sdo_oe <= 1'b0;
        end else if (cs_n) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= out_drive && !out_bit; // RULE7 RULE8
        end
    end

    // system side on mclk
    logic cs_q1;
    logic cs_q2;
    logic cs_q3;
    logic srst_q1;
    logic srst_q2;
    logic srst_q3;
    logic [15:0] init_cnt;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdo_out <= 1'b0; // RULE8
        end else begin
            sdo_out <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cs_q1 <= 1'b1;
            cs_q2 <= 1'b1;
            cs_q3 <= 1'b1;
            srst_q1 <= 1'b0;
            srst_q2 <= 1'b0;
            srst_q3 <= 1'b0;
        end else begin
            cs_q1 <= cs_n;
            cs_q2 <= cs_q1;
            cs_q3 <= cs_q2;
            srst_q1 <= srst_tgl;
            srst_q2 <= srst_q1;
            srst_q3 <= srst_q2;
        end
    end

    // link-side words are stable while cs_n is high, so the synced rise qualifies them
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            switch_closed <= swc_pkg::SWITCH_RST; // RULE24
        end else if (cs_q2 && !cs_q3) begin
            if (mode == swc_pkg::SWC_DAISY_MODE) begin
                switch_closed <= sh[7:0]; // RULE21
            end else begin
                switch_closed <= regs.sw; // RULE23
            end
        end
    end

    // status only: commands during the wait are not refused
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            init_cnt <= 16'h0000;
            init_done <= 1'b0;
        end else if (srst_q2 != srst_q3) begin
            init_cnt <= 16'h0000; // RULE22
            init_done <= 1'b0;
        end else if (init_cnt == 16'(INIT_CYCLES - 1)) begin
            init_done <= 1'b1; // RULE22
        end else begin
            init_cnt <= 16'(init_cnt + 16'h0001);
        end
    end

endmodule

//--- core/swc_pkg.sv
// constants, register layout and types for the switch-bank serial target
// assumes one host on a four-wire serial link, sclk idle high between frames
package swc_pkg;

    // frame geometry
    localparam int CMD_BITS = 16;
    localparam int CRC_BITS = 8;
    localparam int CRC_FRAME_BITS = CMD_BITS + CRC_BITS;
    localparam int BYTE_BITS = 8;
    localparam int READ_DECIDE_BIT = 8;
    localparam int ADDR_DECIDE_BIT = 9;

    // register offsets
    localparam logic [6:0] ADDR_SWITCH = 7'h01;
    localparam logic [6:0] ADDR_ERR_CFG = 7'h02;
    localparam logic [6:0] ADDR_ERR_FLAGS = 7'h03;
    localparam logic [6:0] ADDR_BURST = 7'h05;
    localparam logic [6:0] ADDR_SRST = 7'h0B;

    // error bit positions, shared by config and flags
    localparam int ERR_CRC = 0;
    localparam int ERR_CLK = 1;
    localparam int ERR_ADDR = 2;

    // reset values
    localparam logic [7:0] SWITCH_RST = 8'h00;
    localparam logic [2:0] ERR_CFG_RST = 3'h6;
    localparam logic [2:0] ERR_FLAGS_RST = 3'h0;
    localparam logic BURST_RST = 1'b0;
    localparam logic [7:0] SRST_RST = 8'h00;

    // special words
    localparam logic [7:0] ALIGN_PATTERN = 8'h25;
    localparam logic [15:0] CLEAR_FLAGS_CMD = 16'h6CA9;
    localparam logic [15:0] DAISY_ENTRY_CMD = 16'h2500;
    localparam logic [15:0] SRST_FIRST_CMD = 16'h0BA3;
    localparam logic [15:0] SRST_SECOND_CMD = 16'h0B05;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'h00;

    // initialisation wait after any reset
    localparam int INIT_TIME_US = 120;
    localparam int CLK_PERIOD_NS = 8;
    localparam int INIT_CYCLES = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] sw;
        logic [2:0] cfg;
        logic [2:0] flags;
        logic burst;
        logic [7:0] srst;
    } swc_regs_t;

    localparam swc_regs_t REGS_RST = '{
        sw: SWITCH_RST,
        cfg: ERR_CFG_RST,
        flags: ERR_FLAGS_RST,
        burst: BURST_RST,
        srst: SRST_RST
    };

    typedef enum logic {
        SWC_ADDR_MODE,
        SWC_DAISY_MODE
    } swc_mode_t;

endpackage

//--- test/swc_spi_target_assertions.sv
// port-level checks for the switch-bank serial target
// assumes it is bound onto the target and sees only its ports
module swc_spi_target_chk #(
    parameter int INIT_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic [7:0] switch_closed,
    input wire logic init_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_cnt;
    // length of the current low stretch of init_done
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_cnt <= 0;
        end else if (init_done) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    chk_sdo_pull_low: assert property (sdo_oe |-> sdo_out == 1'b0)
        else $error("sdo driven high");
    chk_cs_release: assert property (cs_n |-> !sdo_oe)
        else $error("sdo held after frame end");
    chk_oe_on_fall: assert property ($changed(sdo_oe) |-> $fell(sclk) || $rose(cs_n))
        else $error("sdo moved off a falling sclk edge");
    chk_drive_in_frame: assert property ($rose(sdo_oe) |-> !cs_n && !sclk)
        else $error("sdo pulled low outside a frame");
    chk_switch_at_cs: assert property ($changed(switch_closed) |-> cs_n)
        else $error("switches moved inside a frame");
    // reset is the enabling condition here, so the default disable is overridden
    chk_reset_opens: assert property (disable iff (!rst) 1'b1 |-> switch_closed == 8'h00 && !init_done)
        else $error("reset left a switch closed");
    chk_init_hold: assert property ($fell(rst) |-> !init_done [*8])
        else $error("init done too early");
    chk_init_count: assert property ($rose(init_done) |-> low_cnt >= INIT_CYCLES - 6 && low_cnt <= INIT_CYCLES + 1)
        else $error("init wait of wrong length");
    cover property ($rose(init_done));
    cover property ($changed(switch_closed));
    cover property ($rose(sdo_oe));
endmodule
bind swc_spi_target swc_spi_target_chk #(.INIT_CYCLES(INIT_CYCLES)) chk_u (.mclk(mclk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .switch_closed(switch_closed), .init_done(init_done));

//--- test/swc_host.sv
// host controller model for the serial link, mode 3 timing
// assumes sdo_line is the open-drain wire with its pull-up applied
module swc_host (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_line
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime HALF = 62.5;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b1;
    end
    // sends w[n-1:0] msb first, gathers the wire at each rising edge
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] g);
        g = '0;
        cs_n = 1'b0;
        #(HALF);
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = w[i];
            #(HALF);
            sclk = 1'b1;
            g = {g[30:0], sdo_line};
            #(HALF);
        end
        cs_n = 1'b1;
        // released data line must not keep its last value
        sdi = ~sdi;
        #(4 * HALF);
    endtask
endmodule

//--- test/swc_spi_target_tb.sv
// self-checking bench for the switch-bank serial target
// assumes the host model and the bound checker are compiled alongside
module swc_spi_target_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] SW = swc_pkg::ADDR_SWITCH;
    localparam logic [6:0] CFG = swc_pkg::ADDR_ERR_CFG;
    localparam logic [6:0] FLG = swc_pkg::ADDR_ERR_FLAGS;
    localparam logic [6:0] SR = swc_pkg::ADDR_SRST;
    logic mclk = 1'b0;
    logic rst;
    logic crc_on = 1'b0;
    logic sclk, cs_n, sdi, sdo_out, sdo_oe, init_done;
    logic [7:0] switch_closed;
    int fails = 0;
    int n_checks = 0;
    wire sdo_line = sdo_oe ? sdo_out : 1'b1;
    always #4 mclk = ~mclk;
    swc_spi_target #(.INIT_CYCLES(20)) dut_u (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .switch_closed(switch_closed), .init_done(init_done));
    swc_host host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));
    task automatic summarize();
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic sw(input logic [7:0] e);
        chk({8'h00, switch_closed}, {8'h00, e});
    endtask
    task automatic wait_init();
        for (int k = 0; init_done !== 1'b1; k++) begin
            @(negedge mclk);
            if (k > 1000) begin
                fails++;
                summarize();
            end
        end
    endtask
    task automatic hw_reset();
        @(negedge mclk);
        rst = 1'b1;
        repeat (6) @(negedge mclk);
        sw(8'h00);
        rst = 1'b0;
        crc_on = 1'b0;
        wait_init();
    endtask
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    // one command per frame; bad flips the lowest bit of the crc byte
    task automatic cmd(input logic [15:0] c, input logic bad, output logic [31:0] g);
        if (crc_on) begin
            host_u.xfer({8'h00, c, crc8(c) ^ {7'h00, bad}}, 24, g);
            g = g >> 8;
        end else begin
            host_u.xfer({16'h0000, c}, 16, g);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [31:0] g;
        cmd({1'b1, a, 8'h00}, 1'b0, g);
        chk(g[15:0], {8'h25, e});
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [31:0] g;
        cmd({1'b0, a, d}, 1'b0, g);
        chk(g[15:0], 16'h2500);
    endtask
    task automatic t_basic();
        logic [31:0] g;
        rd(CFG, 8'h06);
        wr(SW, 8'hA5);
        sw(8'hA5);
        rd(SW, 8'hA5);
        wr(7'h7F, 8'h11);
        wr(FLG, 8'h07);
        rd(FLG, 8'h04);
        rd(SW, 8'hA5);
        rd(FLG, 8'h04);
        cmd(16'h6CA9, 1'b0, g);
        rd(FLG, 8'h00);
    endtask
    task automatic t_count();
        logic [31:0] g;
        host_u.xfer({20'h0_0000, 12'h01F}, 12, g);
        rd(FLG, 8'h02);
        sw(8'hA5);
        cmd(16'h6CA9, 1'b0, g);
        host_u.xfer({12'h000, 16'h013C, 4'h0}, 20, g);
        rd(SW, 8'h3C);
        rd(FLG, 8'h02);
        cmd(16'h6CA9, 1'b0, g);
    endtask
    task automatic t_crc();
        logic [31:0] g;
        wr(CFG, 8'h07);
        crc_on = 1'b1;
        wr(SW, 8'h5A);
        sw(8'h5A);
        cmd(16'h01C3, 1'b1, g);
        sw(8'h5A);
        // nonzero register data so the appended crc must cover the read-back byte
        host_u.xfer({8'h00, 16'h8100, crc8(16'h8100)}, 24, g);
        chk(g[23:8], 16'h255A);
        chk({8'h00, g[7:0]}, {8'h00, crc8(16'h815A)});
        rd(FLG, 8'h01);
        cmd(16'h6CA9, 1'b1, g);
        rd(FLG, 8'h01);
        cmd(16'h6CA9, 1'b0, g);
        rd(FLG, 8'h00);
        hw_reset();
    endtask
    task automatic t_burst();
        logic [31:0] g;
        wr(swc_pkg::ADDR_BURST, 8'h01);
        host_u.xfer(32'h0166_8100, 32, g);
        chk(g[31:16], 16'h2500);
        chk(g[15:0], 16'h2566);
        host_u.xfer(32'h0081_0000, 24, g);
        rd(FLG, 8'h02);
        wr(SR, 8'hA3);
        wr(SW, 8'h11);
        wr(SR, 8'h05);
        rd(swc_pkg::ADDR_BURST, 8'h01);
        wr(SR, 8'hA3);
        wr(SR, 8'h05);
        sw(8'h00);
        wait_init();
        rd(swc_pkg::ADDR_BURST, 8'h00);
        rd(FLG, 8'h00);
    endtask
    task automatic t_daisy();
        logic [31:0] g;
        cmd(16'h2500, 1'b0, g);
        chk(g[15:0], 16'h2500);
        host_u.xfer(32'h0000_1234, 16, g);
        chk(g[15:0], 16'h0012);
        sw(8'h34);
        host_u.xfer(32'h0000_0ABC, 12, g);
        chk(g[15:0], 16'h034A);
        sw(8'hBC);
        hw_reset();
        rd(SW, 8'h00);
    endtask
    initial begin
        // assigned here, not at declaration, so the asynchronous reset sees a rising edge
        rst = 1'b1;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        wait_init();
        t_basic();
        t_count();
        t_crc();
        t_burst();
        t_daisy();
        summarize();
    end
endmodule
